// *** rcb_defines.svh ***
/*
 * Constants for the repeater cascade bus and configuration load block.
 * Assumes a 200 MHz block clock and 10 Mb/s bit times on the cascade bus.
 */
// Behaviour
// - Arbitration in/out pair works as daisy chain or through external arbiter.
// - Activity and any-collision lines are wired, driven and sensed at once.
// - Only one device drives packet enable, data, clock and collision at a time.
// - Each single-driver signal is driven or received, never both.
// - Split-pin variant uses separate drive and sense pins for wired lines.
// - Transceiver packet-enable output is drive enable and sense disable.
// - Processor pins are shared by config load, display refresh, register access.
// - Display refresh runs on its own, no processor needed.
// - Config-load input low holds timers, state machines and partition in reset.
// - Rising edge of config-load captures data and address pins into config.
// - Bypass bits D0, D1 select external or internal transceivers for ports 2-7.
// - Processor or simple logic reads and writes internal registers over shared pins.
// - Entering transmit collision holds any-collision asserted for 96 bit times.
// - Asserted collision-present makes the core send jam instead of buffered data.
`ifndef RCB_DEFINES_SVH
`define RCB_DEFINES_SVH

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define RCB_CLK_PERIOD_NS 5
`define RCB_BIT_TIME_NS 100
`define RCB_JAM_BITS 96
`define RCB_JAM_CYCLES ((`RCB_JAM_BITS * `RCB_BIT_TIME_NS + `RCB_CLK_PERIOD_NS - 1) / `RCB_CLK_PERIOD_NS)
`define RCB_HOLD_W 11
`define RCB_DISP_STEP_CYCLES 4

// ----------------------------------------------------------------
// configuration load
// ----------------------------------------------------------------
`define RCB_CFG_DATA_RST 8'h00
`define RCB_CFG_ADDR_RST 5'h00
`define RCB_BYP_LO_BIT 0
`define RCB_BYP_HI_BIT 1
`define RCB_BYP_ALL_EXT 2'h0
`define RCB_BYP_EXT_2_3 2'h1
`define RCB_BYP_EXT_2_5 2'h2
`define RCB_EXT_MASK_ALL 6'h3F
`define RCB_EXT_MASK_2_3 6'h03
`define RCB_EXT_MASK_2_5 6'h0F
`define RCB_EXT_MASK_NONE 6'h00

// ----------------------------------------------------------------
// register access over the shared pins
// ----------------------------------------------------------------
`define RCB_REG_PORT_DIS 5'h00
`define RCB_REG_STATUS 5'h01
`define RCB_PORT_DIS_RST 8'h00
`define RCB_SYNC_W 23
// load pin bit resets low: a high reset value would fake a config edge
`define RCB_SYNC_RST 23'h3FFFFF

`endif

// *** rcb_pkg.sv ***
/*
 * Types for the repeater cascade bus block.
 * Assumes rcb_defines.svh holds all numeric constants.
 */
package rcb_pkg;

    // one bit per single-driver cascade signal
    typedef struct packed {
        logic en_n;
        logic data;
        logic clk;
        logic coll_n;
    } rcb_pkt_t;

    // requests from the repeater core, same clock
    typedef struct packed {
        logic arb_req;
        logic activity;
        logic drive_bus;
        logic pkt_en;
        logic data;
        logic clk;
        logic coll;
        logic tx_coll_enter;
        logic multi_coll;
    } rcb_core_t;

    // sensed cascade state for the core
    typedef struct packed {
        logic activity;
        logic any_coll;
        logic pkt_en;
        logic coll;
        logic bit_valid;
        logic bit_val;
    } rcb_bus_t;

    typedef enum logic [1:0] {
        RCB_DISP_IDLE = 2'b00,
        RCB_DISP_SETUP = 2'b01,
        RCB_DISP_STROBE = 2'b10,
        RCB_DISP_HOLD = 2'b11
    } rcb_disp_st_t;

endpackage : rcb_pkg

// *** rcb_disp_scan.sv ***
/*
 * Autonomous LED refresh scanner: walks eight status bits out to an
 * addressable latch, one address and strobe per bit.
 * Assumes run drops whenever a processor access claims the shared pins.
 */
`timescale 1ns/100ps
`include "rcb_defines.svh"

module rcb_disp_scan #(
    parameter int STEP = `RCB_DISP_STEP_CYCLES
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // control and data
    input wire logic run,
    input wire logic [7:0] status,
    // latch side
    output logic [2:0] idx,
    output logic led_bit,
    output logic strobe,
    output logic active
);
    import rcb_pkg::*;

    rcb_disp_st_t st_q, st_d;
    logic [2:0] idx_q, idx_d;
    logic [7:0] cnt_q, cnt_d;
    logic bit_q, bit_d;

    // ----------------------------------------------------------------
    // scan sequence
    // ----------------------------------------------------------------
    always_comb begin
        st_d = st_q;
        idx_d = idx_q;
        cnt_d = cnt_q;
        bit_d = bit_q;
        if (!run) begin
            // abort at once so the pins are free for the processor
            st_d = RCB_DISP_IDLE;
        end else begin
            case (st_q)
                RCB_DISP_IDLE: begin
                    st_d = RCB_DISP_SETUP;
                    cnt_d = 8'(STEP - 1);
                    bit_d = status[idx_q];
                end
                RCB_DISP_SETUP: begin
                    if (cnt_q == 8'h00) begin
                        st_d = RCB_DISP_STROBE;
                    end else begin
                        cnt_d = cnt_q - 8'h01;
                    end
                end
                RCB_DISP_STROBE: begin
                    st_d = RCB_DISP_HOLD;
                    cnt_d = 8'(STEP - 1);
                end
                default: begin
                    if (cnt_q == 8'h00) begin
                        st_d = RCB_DISP_IDLE;
                        idx_d = idx_q + 3'h1;
                    end else begin
                        cnt_d = cnt_q - 8'h01;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_q <= RCB_DISP_IDLE;
            idx_q <= 3'h0;
            cnt_q <= 8'h00;
            bit_q <= 1'b0;
        end else begin
            st_q <= st_d;
            idx_q <= idx_d;
            cnt_q <= cnt_d;
            bit_q <= bit_d;
        end
    end

    assign idx = idx_q;
    assign led_bit = bit_q;
    assign strobe = (st_q == RCB_DISP_STROBE);
    assign active = (st_q != RCB_DISP_IDLE);

    scan_steps_a: assert property (@(posedge clk) disable iff (!rst_n)
        strobe |=> !strobe) else $error("display strobe longer than one cycle");

endmodule : rcb_disp_scan

// *** rcb_cascade.sv ***
/*
 * Cascade bus pin interface and power-up configuration load of a
 * multiport repeater, plus the shared processor/display pin multiplexer.
 * Assumes the repeater core sits on CLOCK and the far side is other
 * repeaters; every pin input is synchronised before use.
 */
`timescale 1ns/100ps
`include "rcb_defines.svh"

module rcb_cascade #(
    parameter bit SPLIT_PINS = 1'b0,
    parameter int JAM_CYCLES = `RCB_JAM_CYCLES
) (
    // clock and reset
    input wire logic CLOCK,
    input wire logic RST_N,
    // configuration load pin
    input wire logic CONFIG_LOAD_RESET_N,
    // shared processor and display pins
    input wire logic [7:0] DATA_I,
    output logic [7:0] DATA_O,
    output logic DATA_OE,
    input wire logic [4:0] ADDR_I,
    output logic [4:0] ADDR_O,
    output logic ADDR_OE,
    input wire logic CPU_RD_N,
    input wire logic CPU_WR_N,
    output logic DISP_STROBE,
    // arbitration chain
    input wire logic ARB_CHAIN_IN_N,
    output logic ARB_CHAIN_OUT_N,
    // wired cascade lines
    input wire logic CASCADE_ACTIVITY_N_I,
    output logic CASCADE_ACTIVITY_N_O,
    output logic CASCADE_ACTIVITY_N_OE,
    input wire logic ANY_TX_COLLISION_N_I,
    output logic ANY_TX_COLLISION_N_O,
    output logic ANY_TX_COLLISION_N_OE,
    // single-driver cascade lines
    input wire rcb_pkg::rcb_pkt_t CASCADE_PKT_I,
    output rcb_pkg::rcb_pkt_t CASCADE_PKT_O,
    output rcb_pkg::rcb_pkt_t CASCADE_PKT_OE,
    output logic XCVR_DRIVE_ENABLE,
    // repeater core side
    input wire rcb_pkg::rcb_core_t CORE_REQ,
    input wire logic [7:0] STATUS_LEDS,
    output logic CORE_RESET_N,
    output rcb_pkg::rcb_bus_t BUS_SENSE,
    output logic SEND_JAM,
    output logic ARB_GRANTED,
    output logic [7:0] CONFIG_DATA,
    output logic [4:0] CONFIG_ADDR,
    output logic [5:0] PORT_EXTERNAL,
    output logic [7:0] PORT_DISABLE
);
    import rcb_pkg::*;

    // ----------------------------------------------------------------
    // pin synchronisers
    // ----------------------------------------------------------------
    logic [`RCB_SYNC_W-1:0] s1_q, s2_q;

    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            s1_q <= `RCB_SYNC_RST;
            s2_q <= `RCB_SYNC_RST;
        end else begin
            s1_q <= {CONFIG_LOAD_RESET_N, ARB_CHAIN_IN_N, CASCADE_ACTIVITY_N_I,
                     ANY_TX_COLLISION_N_I, CASCADE_PKT_I, CPU_RD_N, CPU_WR_N, DATA_I, ADDR_I};
            s2_q <= s1_q;
        end
    end

    logic load_s, arb_in_n_s, act_n_s, any_n_s, rd_n_s, wr_n_s;
    rcb_pkt_t pkt_s;
    logic [7:0] data_s;
    logic [4:0] addr_s;
    assign {load_s, arb_in_n_s, act_n_s, any_n_s, pkt_s, rd_n_s, wr_n_s, data_s, addr_s} = s2_q;

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    logic load_prev_q, load_prev_d, run_q, run_d;
    logic [7:0] cfg_data_q, cfg_data_d;
    logic [4:0] cfg_addr_q, cfg_addr_d;
    logic [5:0] port_ext_q, port_ext_d;
    logic arb_out_q, arb_out_d, act_q, act_d, any_q, any_d;
    logic [`RCB_HOLD_W-1:0] hold_cnt_q, hold_cnt_d;
    localparam logic [`RCB_HOLD_W-1:0] JAM_LOAD = JAM_CYCLES[`RCB_HOLD_W-1:0];
    logic drive_q, drive_d, jam_q, jam_d, clk_prev_q, clk_prev_d;
    rcb_pkt_t pkt_o_q, pkt_o_d;
    rcb_bus_t bus_q, bus_d;
    logic rd_act_q, rd_act_d, wr_prev_q, wr_prev_d;
    logic [7:0] data_o_q, data_o_d, port_dis_q, port_dis_d;
    logic load_rise, disp_run, disp_active, disp_bit;
    logic [2:0] disp_idx;

    assign load_rise = load_s && !load_prev_q;
    // display owns the pins only while no processor strobe is seen
    assign disp_run = run_q && rd_n_s && wr_n_s && wr_prev_q;

    always_comb begin
        load_prev_d = load_s;
        run_d = load_s;
        cfg_data_d = cfg_data_q;
        cfg_addr_d = cfg_addr_q;
        port_ext_d = port_ext_q;
        if (load_rise) begin
            cfg_data_d = data_s;
            cfg_addr_d = addr_s;
            case ({data_s[`RCB_BYP_HI_BIT], data_s[`RCB_BYP_LO_BIT]})
                `RCB_BYP_ALL_EXT: port_ext_d = `RCB_EXT_MASK_ALL;
                `RCB_BYP_EXT_2_3: port_ext_d = `RCB_EXT_MASK_2_3;
                `RCB_BYP_EXT_2_5: port_ext_d = `RCB_EXT_MASK_2_5;
                default: port_ext_d = `RCB_EXT_MASK_NONE;
            endcase
        end
        // chain passes higher priority through, adds our own request
        arb_out_d = run_q && (!arb_in_n_s || CORE_REQ.arb_req);
        act_d = run_q && CORE_REQ.activity;
        if (!run_q) begin
            hold_cnt_d = '0;
        end else if (CORE_REQ.tx_coll_enter) begin
            hold_cnt_d = JAM_LOAD;
        end else if (hold_cnt_q != '0) begin
            hold_cnt_d = hold_cnt_q - `RCB_HOLD_W'(1);
        end else begin
            hold_cnt_d = hold_cnt_q;
        end
        any_d = run_q && (hold_cnt_d != '0 || CORE_REQ.multi_coll);
        // release the lines as soon as the load pin drops, not a cycle later
        drive_d = run_q && load_s && CORE_REQ.drive_bus;
        pkt_o_d.en_n = !CORE_REQ.pkt_en;
        pkt_o_d.data = CORE_REQ.data;
        pkt_o_d.clk = CORE_REQ.clk;
        pkt_o_d.coll_n = !CORE_REQ.coll;
        // sensed packet enable and collision are masked out of BUS_SENSE while we drive them ourselves; jam still uses sensed collision
        clk_prev_d = pkt_s.clk;
        bus_d.activity = !act_n_s;
        bus_d.any_coll = !any_n_s;
        bus_d.pkt_en = !drive_q && !pkt_s.en_n;
        bus_d.coll = !drive_q && !pkt_s.coll_n;
        bus_d.bit_valid = bus_d.pkt_en && pkt_s.clk && !clk_prev_q;
        bus_d.bit_val = pkt_s.data;
        jam_d = run_q && (!pkt_s.coll_n || (drive_q && CORE_REQ.coll));
        // register access: read drives data, write lands at strobe end
        rd_act_d = run_q && !rd_n_s;
        wr_prev_d = wr_n_s;
        if (addr_s == `RCB_REG_PORT_DIS) begin
            data_o_d = port_dis_q;
        end else if (addr_s == `RCB_REG_STATUS) begin
            data_o_d = STATUS_LEDS;
        end else begin
            data_o_d = 8'h00;
        end
        port_dis_d = port_dis_q;
        if (run_q && wr_n_s && !wr_prev_q && addr_s == `RCB_REG_PORT_DIS) begin
            port_dis_d = data_s;
        end
    end

    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            load_prev_q <= 1'b0;
            run_q <= 1'b0;
            cfg_data_q <= `RCB_CFG_DATA_RST;
            cfg_addr_q <= `RCB_CFG_ADDR_RST;
            port_ext_q <= `RCB_EXT_MASK_ALL;
            arb_out_q <= 1'b0;
            act_q <= 1'b0;
            any_q <= 1'b0;
            hold_cnt_q <= '0;
            drive_q <= 1'b0;
            jam_q <= 1'b0;
            clk_prev_q <= 1'b1;
            pkt_o_q <= '1;
            bus_q <= '0;
            rd_act_q <= 1'b0;
            wr_prev_q <= 1'b1;
            data_o_q <= 8'h00;
            port_dis_q <= `RCB_PORT_DIS_RST;
        end else begin
            load_prev_q <= load_prev_d;
            run_q <= run_d;
            cfg_data_q <= cfg_data_d;
            cfg_addr_q <= cfg_addr_d;
            port_ext_q <= port_ext_d;
            arb_out_q <= arb_out_d;
            act_q <= act_d;
            any_q <= any_d;
            hold_cnt_q <= hold_cnt_d;
            drive_q <= drive_d;
            jam_q <= jam_d;
            clk_prev_q <= clk_prev_d;
            pkt_o_q <= pkt_o_d;
            bus_q <= bus_d;
            rd_act_q <= rd_act_d;
            wr_prev_q <= wr_prev_d;
            data_o_q <= data_o_d;
            port_dis_q <= port_dis_d;
        end
    end

    rcb_disp_scan #(.STEP(`RCB_DISP_STEP_CYCLES)) u_disp (
        .clk(CLOCK),
        .rst_n(RST_N),
        .run(disp_run),
        .status(STATUS_LEDS),
        .idx(disp_idx),
        .led_bit(disp_bit),
        .strobe(DISP_STROBE),
        .active(disp_active)
    );

    // ----------------------------------------------------------------
    // pin drive
    // ----------------------------------------------------------------
    // split variant drives a dedicated pin always; else open drain
    assign CASCADE_ACTIVITY_N_O = SPLIT_PINS ? !act_q : 1'b0;
    assign CASCADE_ACTIVITY_N_OE = SPLIT_PINS ? 1'b1 : act_q;
    assign ANY_TX_COLLISION_N_O = SPLIT_PINS ? !any_q : 1'b0;
    assign ANY_TX_COLLISION_N_OE = SPLIT_PINS ? 1'b1 : any_q;
    assign ARB_CHAIN_OUT_N = !arb_out_q;
    assign ARB_GRANTED = run_q && arb_in_n_s && CORE_REQ.arb_req;
    assign CASCADE_PKT_O = pkt_o_q;
    assign CASCADE_PKT_OE = {4{drive_q}};
    assign XCVR_DRIVE_ENABLE = drive_q;
    assign ADDR_OE = disp_active;
    assign ADDR_O = {2'b00, disp_idx};
    assign DATA_OE = rd_act_q || disp_active;
    assign DATA_O = rd_act_q ? data_o_q : {7'h00, disp_bit};
    assign CORE_RESET_N = run_q;
    assign BUS_SENSE = bus_q;
    assign SEND_JAM = jam_q || bus_q.any_coll;
    assign CONFIG_DATA = cfg_data_q;
    assign CONFIG_ADDR = cfg_addr_q;
    assign PORT_EXTERNAL = port_ext_q;
    assign PORT_DISABLE = port_dis_q;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (!RST_N);

    load_reset_hold_a: assert property (!load_s |=> !CORE_RESET_N && !XCVR_DRIVE_ENABLE)
        else $error("core not held in reset during config load");
    config_capture_a: assert property (load_rise |=> CONFIG_DATA == $past(data_s))
        else $error("config data not captured on load edge");
    bypass_decode_a: assert property (load_rise && data_s[1:0] == 2'h1 |=> PORT_EXTERNAL == 6'h03)
        else $error("bypass code 01 decoded wrongly");
    single_drive_a: assert property ((CASCADE_PKT_OE.en_n == XCVR_DRIVE_ENABLE) && !($past(drive_q) && BUS_SENSE.pkt_en))
        else $error("packet lines driven and sensed together");
    drive_follow_a: assert property (run_q && load_s && CORE_REQ.drive_bus |=> XCVR_DRIVE_ENABLE)
        else $error("transceiver enable missing while driving");
    jam_hold_a: assert property (run_q && load_s && CORE_REQ.tx_coll_enter |=> any_q [*8])
        else $error("any-collision not held after collision entry");
    jam_length_a: assert property (run_q && load_s && CORE_REQ.tx_coll_enter |=> hold_cnt_q == JAM_LOAD)
        else $error("collision hold length wrong");
    coll_jam_a: assert property (run_q && load_s && !pkt_s.coll_n |=> SEND_JAM)
        else $error("collision present did not select jam");
    pin_share_a: assert property (!rd_n_s |=> !ADDR_OE)
        else $error("display kept address pins during processor access");
    wired_sense_a: assert property (!act_n_s |=> BUS_SENSE.activity)
        else $error("activity line not sensed");

    load_seen_c: cover property (load_rise);
    tx_coll_c: cover property (run_q && CORE_REQ.tx_coll_enter);
    bus_bit_c: cover property (BUS_SENSE.bit_valid);
    cpu_write_c: cover property (run_q && wr_n_s && !wr_prev_q);

endmodule : rcb_cascade

// *** rcb_peer.sv ***
/* Far-side repeater model: resolves every cascade wire.
   Assumes the bench starts frames and wired assertions. */
`timescale 1ns/100ps

module rcb_peer (
    // clock
    input wire logic clk,
    // device drive
    input wire rcb_pkg::rcb_pkt_t dut_o,
    input wire rcb_pkg::rcb_pkt_t dut_oe,
    input wire logic act_o,
    input wire logic act_oe,
    input wire logic anyx_o,
    input wire logic anyx_oe,
    // resolved wires
    output rcb_pkg::rcb_pkt_t pkt,
    output logic act_n,
    output logic anyx_n
);
    import rcb_pkg::*;
    logic drv = 1'b0;
    rcb_pkt_t val = 4'hF;
    logic p_act = 1'b0;
    logic p_anyx = 1'b0;

    // ----------------------------------------
    // wires
    // ----------------------------------------
    // released lines rest at their pull-up level, the idle state of the bus
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            pkt[i] = dut_oe[i] ? dut_o[i] : (drv ? val[i] : 1'b1);
        end
    end
    assign act_n = ~(p_act | (act_oe & ~act_o));
    assign anyx_n = ~(p_anyx | (anyx_oe & ~anyx_o));

    // ----------------------------------------
    // frames
    // ----------------------------------------
    // link clock stands still outside the frame
    task automatic send_byte(input logic [7:0] b);
        val = 4'h1;
        drv = 1'b1;
        #48;
        for (int i = 0; i < 8; i++) begin
            val.data = b[i];
            #24 val.clk = 1'b1;
            #24 val.clk = 1'b0;
        end
        #48 drv = 1'b0;
    endtask : send_byte

    task automatic set_coll(input logic on);
        val = {1'b0, 1'b0, 1'b0, ~on};
        drv = on;
    endtask : set_coll
endmodule : rcb_peer

// *** rcb_cascade_bench.sv ***
/* Self-checking bench for the cascade pins and configuration load.
   Assumes rcb_peer stands on the far side of the cascade bus. */
`timescale 1ns/100ps

module rcb_cascade_bench;
    import rcb_pkg::*;
    localparam int JAM_CYC = 20;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic cfg_n = 1'b0;
    logic [7:0] d_drv = 8'h00;
    logic [4:0] a_drv = 5'h00;
    logic rd_n = 1'b1;
    logic wr_n = 1'b1;
    logic arb_in_n = 1'b1;
    logic granted;
    rcb_core_t core = '0;
    logic [7:0] leds = 8'hA5;
    logic [7:0] data_o, cfg_d, dis;
    logic [4:0] addr_o, cfg_a;
    logic [5:0] ext;
    logic data_oe, addr_oe, disp_stb, chain_n, xcvr, core_rst_n, send_jam;
    logic act_o, act_oe, anyx_o, anyx_oe, act_n, anyx_n;
    rcb_pkt_t pkt_o, pkt_oe, pkt_i;
    rcb_bus_t sense;
    int miscompares = 0;
    int samples_checked = 0;

    rcb_cascade #(.JAM_CYCLES(JAM_CYC)) i_rcb_cascade (
        .CLOCK(clk), .RST_N(rst_n), .CONFIG_LOAD_RESET_N(cfg_n),
        .DATA_I(data_oe ? data_o : d_drv), .DATA_O(data_o), .DATA_OE(data_oe),
        .ADDR_I(addr_oe ? addr_o : a_drv), .ADDR_O(addr_o), .ADDR_OE(addr_oe),
        .CPU_RD_N(rd_n), .CPU_WR_N(wr_n), .DISP_STROBE(disp_stb),
        .ARB_CHAIN_IN_N(arb_in_n), .ARB_CHAIN_OUT_N(chain_n),
        .CASCADE_ACTIVITY_N_I(act_n), .CASCADE_ACTIVITY_N_O(act_o),
        .CASCADE_ACTIVITY_N_OE(act_oe), .ANY_TX_COLLISION_N_I(anyx_n),
        .ANY_TX_COLLISION_N_O(anyx_o), .ANY_TX_COLLISION_N_OE(anyx_oe),
        .CASCADE_PKT_I(pkt_i), .CASCADE_PKT_O(pkt_o), .CASCADE_PKT_OE(pkt_oe),
        .XCVR_DRIVE_ENABLE(xcvr), .CORE_REQ(core), .STATUS_LEDS(leds),
        .CORE_RESET_N(core_rst_n), .BUS_SENSE(sense), .SEND_JAM(send_jam),
        .ARB_GRANTED(granted), .CONFIG_DATA(cfg_d), .CONFIG_ADDR(cfg_a),
        .PORT_EXTERNAL(ext), .PORT_DISABLE(dis));

    rcb_peer i_rcb_peer (.clk(clk), .dut_o(pkt_o), .dut_oe(pkt_oe), .act_o(act_o),
        .act_oe(act_oe), .anyx_o(anyx_o), .anyx_oe(anyx_oe), .pkt(pkt_i),
        .act_n(act_n), .anyx_n(anyx_n));

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    initial forever #2.5 clk = ~clk;

    task automatic tick(input int n);
        repeat (n) @(negedge clk);
    endtask : tick

    task automatic check(input logic ok, input string msg);
        samples_checked++;
        if (ok !== 1'b1) begin
            miscompares++;
            $display("ERROR %0t %s", $time, msg);
        end
    endtask : check

    task automatic print_verdict();
        if (miscompares == 0 && samples_checked > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : print_verdict

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_reset();
        check(core_rst_n === 1'b0 && ext === 6'h3F && cfg_d === 8'h00, "reset cfg");
        check(dis === 8'h00 && xcvr === 1'b0 && pkt_oe === 4'h0, "reset pins");
    endtask : t_reset

    task automatic t_config();
        logic [5:0] tbl [4] = '{6'h3F, 6'h03, 6'h0F, 6'h00};
        for (int c = 0; c < 4; c++) begin
            cfg_n = 1'b0;
            core.drive_bus = 1'b1;
            d_drv = {6'h2A, c[1:0]};
            a_drv = 5'h10 + 5'(c);
            tick(5);
            check(core_rst_n === 1'b0 && xcvr === 1'b0, "core not held");
            cfg_n = 1'b1;
            tick(6);
            check(cfg_d === d_drv && cfg_a === a_drv, "capture");
            check(ext === tbl[c] && core_rst_n === 1'b1, "bypass");
        end
        core.drive_bus = 1'b0;
        tick(2);
    endtask : t_config

    task automatic t_drive();
        core.drive_bus = 1'b1;
        core.pkt_en = 1'b1;
        core.data = 1'b1;
        tick(2);
        check(xcvr === 1'b1 && pkt_oe === 4'hF, "drive on");
        check(pkt_o.en_n === 1'b0 && pkt_o.data === 1'b1, "drive val");
        core = '0;
        tick(2);
        check(xcvr === 1'b0 && pkt_oe === 4'h0, "drive off");
    endtask : t_drive

    task automatic t_arb();
        core.arb_req = 1'b1;
        tick(2);
        check(chain_n === 1'b0 && granted === 1'b1, "own request");
        arb_in_n = 1'b0;
        tick(4);
        check(chain_n === 1'b0 && granted === 1'b0, "higher request");
        core.arb_req = 1'b0;
        tick(4);
        check(chain_n === 1'b0 && granted === 1'b0, "pass through");
        arb_in_n = 1'b1;
        tick(4);
        check(chain_n === 1'b1 && granted === 1'b0, "chain idle");
    endtask : t_arb

    task automatic t_wired();
        i_rcb_peer.p_act = 1'b1;
        tick(5);
        core.activity = 1'b1;
        check(sense.activity === 1'b1, "sense peer act");
        tick(2);
        check(act_oe === 1'b1 && act_o === 1'b0, "own act");
        i_rcb_peer.p_act = 1'b0;
        tick(5);
        check(sense.activity === 1'b1, "sense own act");
        core.activity = 1'b0;
        i_rcb_peer.p_anyx = 1'b1;
        tick(5);
        check(sense.activity === 1'b0 && act_oe === 1'b0, "act off");
        check(sense.any_coll === 1'b1 && send_jam === 1'b1, "any coll");
        i_rcb_peer.p_anyx = 1'b0;
        i_rcb_peer.set_coll(1'b1);
        tick(5);
        check(sense.coll === 1'b1 && send_jam === 1'b1, "coll jam");
        i_rcb_peer.set_coll(1'b0);
        tick(5);
        check(sense.coll === 1'b0 && send_jam === 1'b0, "coll off");
    endtask : t_wired

    task automatic t_jam();
        int n = 0;
        core.tx_coll_enter = 1'b1;
        tick(1);
        core.tx_coll_enter = 1'b0;
        repeat (JAM_CYC + 10) begin
            if (anyx_oe === 1'b1 && anyx_o === 1'b0) n++;
            tick(1);
        end
        check(n >= JAM_CYC && n <= JAM_CYC + 1, "jam hold");
        core.multi_coll = 1'b1;
        tick(2);
        check(anyx_oe === 1'b1 && anyx_o === 1'b0, "multi coll on");
        core.multi_coll = 1'b0;
        tick(2);
        check(anyx_oe === 1'b0, "multi coll off");
    endtask : t_jam

    task automatic t_rx();
        int n = 0;
        logic [7:0] got = 8'h00;
        fork
            i_rcb_peer.send_byte(8'hC6);
            repeat (200) begin
                tick(1);
                if (sense.bit_valid === 1'b1) begin
                    got[n[2:0]] = sense.bit_val;
                    n++;
                end
            end
        join
        check(n == 8 && got === 8'hC6, "rx bits");
    endtask : t_rx

    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        a_drv = a;
        d_drv = d;
        tick(1);
        wr_n = 1'b0;
        tick(4);
        wr_n = 1'b1;
        tick(6);
    endtask : wr

    task automatic rd(input logic [4:0] a, input logic [7:0] e);
        a_drv = a;
        tick(1);
        rd_n = 1'b0;
        tick(6);
        check(data_oe === 1'b1 && data_o === e && addr_oe === 1'b0, "read");
        rd_n = 1'b1;
        tick(6);
    endtask : rd

    task automatic t_cpu();
        wr(5'h00, 8'h5C);
        check(dis === 8'h5C, "write");
        wr(5'h05, 8'hFF);
        check(dis === 8'h5C, "bad addr");
        rd(5'h00, 8'h5C);
        rd(5'h01, leds);
        rd(5'h07, 8'h00);
    endtask : t_cpu

    task automatic t_disp();
        logic [2:0] prev;
        int k;
        for (int b = 0; b < 9; b++) begin
            k = 0;
            while (disp_stb !== 1'b1 && k < 40) begin
                tick(1);
                k++;
            end
            check(k < 40 && addr_oe === 1'b1 && data_oe === 1'b1, "strobe");
            check(data_o[0] === leds[addr_o[2:0]] && addr_o[4:3] === 2'h0, "bit");
            if (b > 0) check(addr_o[2:0] === prev + 3'h1, "order");
            prev = addr_o[2:0];
            tick(1);
        end
    endtask : t_disp

    // ----------------------------------------
    // sequence
    // ----------------------------------------
    initial begin
        tick(5);
        t_reset();
        rst_n = 1'b1;
        t_config();
        t_drive();
        t_arb();
        t_wired();
        t_jam();
        t_rx();
        t_cpu();
        t_disp();
        print_verdict();
    end

    // run needs about 2.5 us; a hang is cut well past that
    initial begin
        #100000;
        miscompares++;
        print_verdict();
    end
endmodule : rcb_cascade_bench
